// file: verilog/vcm_controller.sv
// bus controller that programs the channel mode registers
`timescale 1ns/100ps
module vcm_controller (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [vcm_pkg::VCM_NUM_CH-1:0][2:0] trigger0_select,
  input wire logic [vcm_pkg::VCM_NUM_CH-1:0][2:0] trigger1_select,
  vcm_link_if.ctl link
);
  import vcm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_WAIT, ST_RESP} vcm_state_type;

  vcm_state_type state_q;
  vcm_state_type state_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic write_q;
  logic write_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic wr_q;
  logic wr_d;
  logic rd_q;
  logic rd_d;
  logic chan_q;
  logic chan_d;
  logic sel_q;
  logic sel_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [VCM_NUM_CH-1:0][1:0] sense_q;
  logic [VCM_NUM_CH-1:0][1:0] sense_d;
  logic take;
  logic link_reg;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic [1:0] code;

  assign take = hsel && htrans[1] && hready && hreadyout;
  assign link_reg = addr_q <= VCM_OFS_FLOW1;
  assign code = hwdata[VCM_OUT_CTRL_LSB +: 2];

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    write_d = write_q;
    hrdata_d = hrdata_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    chan_d = chan_q;
    sel_d = sel_q;
    wdata_d = wdata_q;
    sense_d = sense_q;
    set_bits = '0;
    clr_bits = '0;
    unique case (state_q)
      ST_IDLE, ST_RESP: begin
        state_d = ST_IDLE;
        if (take) begin
          state_d = ST_DATA;
          addr_d = haddr[7:0];
          write_d = hwrite;
        end
      end
      ST_DATA: begin
        state_d = ST_RESP;
        chan_d = addr_q[3];
        sel_d = addr_q[2];
        hrdata_d = 32'h00000000;
        if (link_reg && !write_q) begin
          rd_d = 1'b1;
          state_d = ST_WAIT;
        end else if (link_reg && sel_d == VCM_SEL_TASK) begin
          if (code == VCM_OUT_RSVD) begin
            set_bits[VCM_ST_RSVD_CODE + chan_d] = 1'b1;
          end else begin
            wr_d = 1'b1;
            wdata_d = hwdata & VCM_TASK_MASK;
          end
        end else if (link_reg) begin
          wr_d = 1'b1;
          wdata_d = hwdata & VCM_FLOW_MASK;
          sense_d[chan_d] = hwdata[VCM_SENSE_LSB +: 2];
          if (hwdata[VCM_CONV_UNIT_LSB +: 2] == (chan_d ? VCM_UNIT_A : VCM_UNIT_B)) begin
            set_bits[VCM_ST_UNIT_MISMATCH + chan_d] = 1'b1;
          end
          if (hwdata[VCM_DRV_CH_BIT] != chan_d) begin
            set_bits[VCM_ST_DRV_MISMATCH + chan_d] = 1'b1;
          end
        end else if (addr_q == VCM_OFS_STATUS && write_q) begin
          clr_bits = hwdata;
        end else if (addr_q == VCM_OFS_STATUS) begin
          hrdata_d = status_q;
        end
      end
      ST_WAIT: begin
        if (link.rvalid) begin
          hrdata_d = link.rdata;
          state_d = ST_RESP;
        end
      end
    endcase
    for (int c = 0; c < VCM_NUM_CH; c++) begin
      if (sense_q[c] == VCM_SENSE_1SHUNT_UP && !(trigger1_select[c] == VCM_TRG_UP
          && (trigger0_select[c] == VCM_TRG_UP || trigger0_select[c] == VCM_TRG_BOTTOM))) begin
        set_bits[VCM_ST_TRIG_MISMATCH + c] = 1'b1;
      end
      if (sense_q[c] == VCM_SENSE_1SHUNT_DOWN && !(trigger0_select[c] == VCM_TRG_DOWN
          && (trigger1_select[c] == VCM_TRG_DOWN
          || trigger1_select[c] == VCM_TRG_BOTTOM))) begin
        set_bits[VCM_ST_TRIG_MISMATCH + c] = 1'b1;
      end
    end
    // set wins over clear
    status_d = ((status_q & ~clr_bits) | set_bits) & VCM_ST_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      addr_q <= 8'h00;
      write_q <= 1'b0;
      hrdata_q <= 32'h00000000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      chan_q <= 1'b0;
      sel_q <= 1'b0;
      wdata_q <= 32'h00000000;
      status_q <= 32'h00000000;
      sense_q <= '0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      write_q <= write_d;
      hrdata_q <= hrdata_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      chan_q <= chan_d;
      sel_q <= sel_d;
      wdata_q <= wdata_d;
      status_q <= status_d;
      sense_q <= sense_d;
    end
  end

  assign hreadyout = state_q == ST_IDLE || state_q == ST_RESP;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign link.wr_en = wr_q;
  assign link.rd_en = rd_q;
  assign link.chan_sel = chan_q;
  assign link.reg_sel = sel_q;
  assign link.wdata = wdata_q;
endmodule : vcm_controller

// file: verilog/vcm_pkg.sv
// shared constants for the vector channel mode registers
package vcm_pkg;
  localparam int VCM_NUM_CH = 2;
  localparam int VCM_DATA_W = 32;
  // register select on the link
  localparam logic VCM_SEL_TASK = 1'h0;
  localparam logic VCM_SEL_FLOW = 1'h1;
  // implemented bits
  localparam logic [31:0] VCM_TASK_MASK = 32'h0000000F;
  localparam logic [31:0] VCM_FLOW_MASK = 32'h000002DF;
  localparam logic [31:0] VCM_RESET_VAL = 32'h00000000;
  // task control mode fields
  localparam int VCM_PHASE_INTERP_BIT = 0;
  localparam int VCM_ZERO_DETECT_BIT = 1;
  localparam int VCM_OUT_CTRL_LSB = 2;
  // flow control fields
  localparam int VCM_TWO_PHASE_BIT = 0;
  localparam int VCM_PWM_SHIFT_BIT = 1;
  localparam int VCM_SENSE_LSB = 2;
  localparam int VCM_DRV_CH_BIT = 4;
  localparam int VCM_CONV_UNIT_LSB = 6;
  localparam int VCM_HOLD_DIS_BIT = 9;
  // output control codes
  localparam logic [1:0] VCM_OUT_OFF = 2'h0;
  localparam logic [1:0] VCM_OUT_ON = 2'h1;
  localparam logic [1:0] VCM_OUT_RSVD = 2'h2;
  localparam logic [1:0] VCM_OUT_OFF_EMG_RET = 2'h3;
  // converter unit codes
  localparam logic [1:0] VCM_UNIT_A = 2'h0;
  localparam logic [1:0] VCM_UNIT_B = 2'h1;
  // driver trigger select codes
  localparam logic [2:0] VCM_TRG_DOWN = 3'h1;
  localparam logic [2:0] VCM_TRG_UP = 3'h2;
  localparam logic [2:0] VCM_TRG_BOTTOM = 3'h5;
  // controller register byte offsets
  localparam logic [7:0] VCM_OFS_TASK0 = 8'h00;
  localparam logic [7:0] VCM_OFS_FLOW0 = 8'h04;
  localparam logic [7:0] VCM_OFS_TASK1 = 8'h08;
  localparam logic [7:0] VCM_OFS_FLOW1 = 8'h0C;
  localparam logic [7:0] VCM_OFS_STATUS = 8'h10;
  // status bits, write one to clear
  localparam int VCM_ST_RSVD_CODE = 0;
  localparam int VCM_ST_UNIT_MISMATCH = 2;
  localparam int VCM_ST_DRV_MISMATCH = 4;
  localparam int VCM_ST_TRIG_MISMATCH = 6;
  localparam logic [31:0] VCM_ST_MASK = 32'h000000FF;

  typedef enum logic [1:0] {
    VCM_SENSE_3SHUNT,
    VCM_SENSE_2SENSOR,
    VCM_SENSE_1SHUNT_UP,
    VCM_SENSE_1SHUNT_DOWN
  } vcm_sense_type;
endpackage : vcm_pkg

// file: verilog/vcm_link_if.sv
// register link between the controller and the channel mode registers
`timescale 1ns/100ps
interface vcm_link_if (
  input wire logic sys_clk
);
  logic wr_en;
  logic rd_en;
  logic chan_sel;
  logic reg_sel;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic rvalid;

  modport dev (
    input wr_en,
    input rd_en,
    input chan_sel,
    input reg_sel,
    input wdata,
    output rdata,
    output rvalid
  );

  modport ctl (
    output wr_en,
    output rd_en,
    output chan_sel,
    output reg_sel,
    output wdata,
    input rdata,
    input rvalid
  );
endinterface : vcm_link_if

// file: verilog/vcm_mode_regs.sv
// per-channel task control mode and flow control registers
`timescale 1ns/100ps
module vcm_mode_regs #(
  parameter int SECTOR_W = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  vcm_link_if.dev link,
  input wire logic [15:0] conversion_time_setting,
  input wire logic [vcm_pkg::VCM_NUM_CH-1:0][15:0] pwm_period_rate,
  input wire logic [vcm_pkg::VCM_NUM_CH-1:0][15:0] sine_result,
  input wire logic [vcm_pkg::VCM_NUM_CH-1:0][15:0] cosine_result,
  input wire logic [vcm_pkg::VCM_NUM_CH-1:0][SECTOR_W-1:0] sector_result,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] output_enable,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] emergency_stop_return,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] zero_current_detect_en,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] phase_interp_en,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] prev_value_hold_disable,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] unit_a_en,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] unit_b_en,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] driver_channel_select,
  output vcm_pkg::vcm_sense_type [vcm_pkg::VCM_NUM_CH-1:0] sense_mode,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] pwm_shift_en,
  output logic [vcm_pkg::VCM_NUM_CH-1:0] two_phase_mod_en,
  output logic [vcm_pkg::VCM_NUM_CH-1:0][15:0] conversion_time_active,
  output logic [vcm_pkg::VCM_NUM_CH-1:0][15:0] pwm_period_active,
  output logic [vcm_pkg::VCM_NUM_CH-1:0][15:0] sine_held,
  output logic [vcm_pkg::VCM_NUM_CH-1:0][15:0] cosine_held,
  output logic [vcm_pkg::VCM_NUM_CH-1:0][SECTOR_W-1:0] sector_held
);
  import vcm_pkg::*;

  if (SECTOR_W < 1 || SECTOR_W > 16) begin : g_bad_width
    $error("SECTOR_W must lie in 1..16");
  end

  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [VCM_NUM_CH-1:0][31:0] task_q;
  logic [VCM_NUM_CH-1:0][31:0] flow_q;

  // link read port, one cycle answer
  always_comb begin
    rvalid_d = link.rd_en;
    rdata_d = rdata_q;
    if (link.rd_en) begin
      rdata_d = (link.reg_sel == VCM_SEL_FLOW) ? flow_q[link.chan_sel] : task_q[link.chan_sel];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_q <= VCM_RESET_VAL;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign link.rdata = rdata_q;
  assign link.rvalid = rvalid_q;

  for (genvar c = 0; c < VCM_NUM_CH; c++) begin : g_ch
    logic [31:0] task_d;
    logic [31:0] flow_d;
    logic emg_ret_q;
    logic emg_ret_d;
    logic [15:0] sine_q;
    logic [15:0] sine_d;
    logic [15:0] cosine_q;
    logic [15:0] cosine_d;
    logic [SECTOR_W-1:0] sector_q;
    logic [SECTOR_W-1:0] sector_d;
    logic [1:0] out_ctrl;
    logic [1:0] unit_sel;
    logic one_shunt;
    logic hit;

    always_comb begin
      hit = link.wr_en && (link.chan_sel == 1'(c));
      task_d = task_q[c];
      flow_d = flow_q[c];
      emg_ret_d = 1'b0;
      if (hit && link.reg_sel == VCM_SEL_TASK) begin
        task_d = link.wdata & VCM_TASK_MASK;
        emg_ret_d = link.wdata[VCM_OUT_CTRL_LSB +: 2] == VCM_OUT_OFF_EMG_RET;
      end
      if (hit && link.reg_sel == VCM_SEL_FLOW) begin
        flow_d = link.wdata & VCM_FLOW_MASK;
      end
      sine_d = sine_q;
      cosine_d = cosine_q;
      sector_d = sector_q;
      if (flow_q[c][VCM_HOLD_DIS_BIT]) begin
        sine_d = sine_result[c];
        cosine_d = cosine_result[c];
        sector_d = sector_result[c];
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
        task_q[c] <= VCM_RESET_VAL;
        flow_q[c] <= VCM_RESET_VAL;
        emg_ret_q <= 1'b0;
        sine_q <= '0;
        cosine_q <= '0;
        sector_q <= '0;
      end else begin
        task_q[c] <= task_d;
        flow_q[c] <= flow_d;
        emg_ret_q <= emg_ret_d;
        sine_q <= sine_d;
        cosine_q <= cosine_d;
        sector_q <= sector_d;
      end
    end

    assign out_ctrl = task_q[c][VCM_OUT_CTRL_LSB +: 2];
    assign unit_sel = flow_q[c][VCM_CONV_UNIT_LSB +: 2];
    assign output_enable[c] = out_ctrl == VCM_OUT_ON;
    assign emergency_stop_return[c] = emg_ret_q;
    assign zero_current_detect_en[c] = task_q[c][VCM_ZERO_DETECT_BIT];
    assign phase_interp_en[c] = task_q[c][VCM_PHASE_INTERP_BIT];
    assign prev_value_hold_disable[c] = flow_q[c][VCM_HOLD_DIS_BIT];
    assign unit_a_en[c] = unit_sel != VCM_UNIT_B;
    assign unit_b_en[c] = unit_sel != VCM_UNIT_A;
    assign driver_channel_select[c] = flow_q[c][VCM_DRV_CH_BIT];
    assign sense_mode[c] = vcm_sense_type'(flow_q[c][VCM_SENSE_LSB +: 2]);
    assign pwm_shift_en[c] = flow_q[c][VCM_PWM_SHIFT_BIT];
    assign two_phase_mod_en[c] = flow_q[c][VCM_TWO_PHASE_BIT];
    assign one_shunt = sense_mode[c] == VCM_SENSE_1SHUNT_UP
      || sense_mode[c] == VCM_SENSE_1SHUNT_DOWN;
    assign conversion_time_active[c] = (one_shunt && pwm_shift_en[c])
      ? conversion_time_setting : 16'h0000;
    assign pwm_period_active[c] = phase_interp_en[c] ? pwm_period_rate[c] : 16'h0000;
    assign sine_held[c] = sine_q;
    assign cosine_held[c] = cosine_q;
    assign sector_held[c] = sector_q;
  end
endmodule : vcm_mode_regs

// file: bench/vcm_link_sva.sv
// checker for the register link between controller and mode registers
`timescale 1ns/100ps
module vcm_link_sva
  import vcm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic chan_sel,
  input wire logic reg_sel,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic rvalid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (rd_en |=> rvalid)
    else $error("read strobe not answered");
  a_answer_cause: assert property (rvalid |-> $past(rd_en))
    else $error("answer without read");
  a_task_rsvd: assert property (wr_en && reg_sel == VCM_SEL_TASK |->
    (wdata & ~VCM_TASK_MASK) == 32'h0) else $error("task write reserved bits");
  a_flow_rsvd: assert property (wr_en && reg_sel == VCM_SEL_FLOW |->
    (wdata & ~VCM_FLOW_MASK) == 32'h0) else $error("flow write reserved bits");
  a_no_rsvd_code: assert property (wr_en && reg_sel == VCM_SEL_TASK |->
    wdata[VCM_OUT_CTRL_LSB +: 2] != VCM_OUT_RSVD) else $error("reserved output code forwarded");
  a_rdata_hold: assert property ($past(reset_n) && !rvalid |-> $stable(rdata))
    else $error("read data moved without answer");
  a_rst_quiet: assert property ($rose(reset_n) |->
    !wr_en && !rd_en && !rvalid && rdata == 32'h0) else $error("link busy after reset");
  a_rdata_rsvd: assert property (rvalid |->
    (rdata & ~($past(reg_sel) ? VCM_FLOW_MASK : VCM_TASK_MASK)) == 32'h0)
    else $error("read data reserved bits");
endmodule : vcm_link_sva

// file: bench/testbench.sv
// self-checking bench for controller and channel mode registers
`timescale 1ns/100ps
module testbench;
  import vcm_pkg::*;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, r;
  logic [1:0][2:0] trg0 = '0;
  logic [1:0][2:0] trg1 = '0;
  logic [15:0] conv = 16'h1234;
  logic [1:0][15:0] rate = 32'hBEEF_5A5A;
  logic [1:0][15:0] sin_i = '0;
  logic [1:0][15:0] cos_i = '0;
  logic [1:0][3:0] sec_i = '0;
  logic [1:0] oe, emergency_stop, zde, pie, hd, ua, ub, drv, shift, twop;
  vcm_sense_type [1:0] sense;
  logic [1:0][15:0] conv_act, per_act, sin_h, cos_h;
  logic [1:0][3:0] sec_h;
  int fail_count = 0;
  int total_checks = 0;
  int emg_cnt = 0;
  vcm_link_if i_vcm_link_if (.sys_clk(sys_clk));
  vcm_controller i_vcm_controller (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .trigger0_select(trg0), .trigger1_select(trg1), .link(i_vcm_link_if));
  vcm_mode_regs #(.SECTOR_W(4)) i_vcm_mode_regs (.sys_clk(sys_clk), .reset_n(reset_n),
    .link(i_vcm_link_if), .conversion_time_setting(conv), .pwm_period_rate(rate),
    .sine_result(sin_i), .cosine_result(cos_i), .sector_result(sec_i),
    .output_enable(oe), .emergency_stop_return(emergency_stop), .zero_current_detect_en(zde),
    .phase_interp_en(pie), .prev_value_hold_disable(hd), .unit_a_en(ua), .unit_b_en(ub),
    .driver_channel_select(drv), .sense_mode(sense), .pwm_shift_en(shift),
    .two_phase_mod_en(twop), .conversion_time_active(conv_act),
    .pwm_period_active(per_act), .sine_held(sin_h), .cosine_held(cos_h), .sector_held(sec_h));
  vcm_link_sva i_vcm_link_sva (.sys_clk(sys_clk), .reset_n(reset_n),
    .wr_en(i_vcm_link_if.wr_en), .rd_en(i_vcm_link_if.rd_en),
    .chan_sel(i_vcm_link_if.chan_sel), .reg_sel(i_vcm_link_if.reg_sel),
    .wdata(i_vcm_link_if.wdata), .rdata(i_vcm_link_if.rdata), .rvalid(i_vcm_link_if.rvalid));

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    emg_cnt <= emg_cnt + int'(emergency_stop[0]) + int'(emergency_stop[1]);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one single AHB transfer; ready and read data taken at the rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask : xfer

  task automatic t_reset;
    for (int a = 0; a < 40; a += 4) begin
      xfer(8'(a), 1'b0, 32'h0);
      chk(r, 32'h0);
    end
    xfer(8'h14, 1'b1, 32'hFFFF_FFFF);
    xfer(8'h14, 1'b0, 32'h0);
    chk(r, 32'h0);
    @(negedge sys_clk);
    chk({ua, oe, ub, drv, twop, shift, zde, pie, sense}, 32'hC0000);
    chk({hd, hresp}, 32'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_out;
    logic [7:0] o;
    for (int c = 0; c < 2; c++) begin
      o = 8'(c * 8);
      xfer(o, 1'b1, 32'hFFFF_FFF7);
      @(negedge sys_clk);
      chk({oe[c], zde[c], pie[c]}, 32'h7);
      chk(per_act[c], rate[c]);
      xfer(o, 1'b1, 32'hB);
      xfer(o, 1'b0, 32'h0);
      chk(r, 32'h7);
      xfer(o, 1'b1, 32'hC);
      @(negedge sys_clk);
      chk(oe[c], 32'h0);
      xfer(o, 1'b1, 32'h0);
      @(negedge sys_clk);
      chk({zde[c], pie[c], per_act[c]}, 32'h0);
    end
    xfer(8'h10, 1'b0, 32'h0);
    chk(r & 32'h3, 32'h3);
    chk(emg_cnt, 32'h2);
    xfer(8'h10, 1'b1, 32'hFF);
    $display("output control test done");
  endtask : t_out

  task automatic t_flow;
    logic [31:0] d;
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 4; i++) begin
        d = 32'(i * 64 + i * 4 + 2 + (i % 2) * 17);
        xfer(8'(c * 8 + 4), 1'b1, d | 32'hFFFF_FD20);
        xfer(8'(c * 8 + 4), 1'b0, 32'h0);
        chk(r, d);
        @(negedge sys_clk);
        chk({ua[c], ub[c], drv[c], twop[c], shift[c]},
          {i != 1, i != 0, i[0], i[0], 1'b1});
        chk(sense[c], i);
        chk(conv_act[c], i > 1 ? conv : 16'h0);
      end
    end
    xfer(8'h04, 1'b1, 32'h8);
    @(negedge sys_clk);
    chk(conv_act[0], 32'h0);
    xfer(8'h04, 1'b1, 32'h0);
    xfer(8'h0C, 1'b1, 32'h0);
    xfer(8'h10, 1'b1, 32'hFF);
    $display("flow control test done");
  endtask : t_flow

  task automatic t_stat;
    trg0[0] <= VCM_TRG_UP;
    trg1[0] <= VCM_TRG_UP;
    xfer(8'h04, 1'b1, 32'h8);
    xfer(8'h10, 1'b1, 32'hFF);
    xfer(8'h10, 1'b0, 32'h0);
    chk(r & 32'h55, 32'h0);
    trg0[0] <= VCM_TRG_DOWN;
    xfer(8'h10, 1'b0, 32'h0);
    chk(r & 32'h40, 32'h40);
    xfer(8'h04, 1'b1, 32'h50);
    xfer(8'h10, 1'b0, 32'h0);
    chk(r & 32'h14, 32'h14);
    xfer(8'h04, 1'b1, 32'h0);
    $display("status test done");
  endtask : t_stat

  task automatic t_hold;
    sin_i <= 32'h1111_2222;
    cos_i <= 32'h3333_4444;
    sec_i <= 8'h5A;
    xfer(8'h04, 1'b1, 32'h200);
    xfer(8'h0C, 1'b1, 32'h200);
    for (int k = 0; k < 2; k++) begin
      repeat (2) @(negedge sys_clk);
      chk(hd, (k == 0) ? 32'h3 : 32'h0);
      chk(sin_h, 32'h1111_2222);
      chk(cos_h, 32'h3333_4444);
      chk(sec_h, 32'h5A);
      xfer(8'h04, 1'b1, 32'h0);
      xfer(8'h0C, 1'b1, 32'h0);
      sin_i <= '0;
      cos_i <= '0;
      sec_i <= '0;
    end
    // mid-run reset clears held copies and status
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk(sin_h, 32'h0);
    chk(sec_h, 32'h0);
    xfer(8'h10, 1'b0, 32'h0);
    chk(r, 32'h0);
    $display("hold test done");
  endtask : t_hold

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test;
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_out;
    t_flow;
    t_stat;
    t_hold;
    end_of_test;
  end
endmodule : testbench
